// ### core/sps_flag.sv
/*
  One sticky status flag, cleared by software writing one.
  Assumes set and clear are one-cycle terms from logic on the same clock.
*/
`timescale 1ns/1ns
module sps_flag (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Set and clear terms.
  input  wire logic set,
  input  wire logic clr,
  // Flag value.
  output logic      flag_r
);

  typedef struct packed {
    logic flag;
  } sps_flag_st_t;

  sps_flag_st_t st_r;
  sps_flag_st_t st_nxt;

  // A set in the same cycle as a clear wins so the event is not lost.
  always_comb begin
    st_nxt = st_r;
    if (set) begin
      st_nxt.flag = 1'h1;
    end else if (clr) begin
      st_nxt.flag = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_r = st_r.flag;

endmodule // sps_flag

// ### core/sps_pkg.sv
/*
  Constants and carrier types for the SPI master status and buffer count registers.
  Assumes a single system clock shared with the transfer engine and the register bus master.
*/
package sps_pkg;

  // Register byte addresses.
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] COUNT_OFS  = 8'h14;
  localparam logic [7:0] INTEN_OFS  = 8'h18;
  localparam logic [7:0] TRIG_OFS   = 8'h1c;

  // Status bit positions.
  localparam int XFER_BIT    = 0;
  localparam int DMA_BIT     = 1;
  localparam int TXERR_BIT   = 2;
  localparam int RXERR_BIT   = 3;
  localparam int PROG_BIT    = 4;
  localparam int TXFULL_BIT  = 8;
  localparam int TXEMPTY_BIT = 9;
  localparam int TXREQ_BIT   = 10;

  // Count and trigger field positions.
  localparam int TXCNT_LSB = 0;
  localparam int RXCNT_LSB = 16;
  localparam int CNT_W     = 16;
  localparam int TRIG_LSB  = 0;

  // Sticky flags, indexed 0 to NFLAG-1, and their status bit positions.
  localparam int NFLAG = 6;
  localparam int FLAG_POS [NFLAG] = '{XFER_BIT, DMA_BIT, TXERR_BIT, RXERR_BIT, PROG_BIT, TXREQ_BIT};

  // Writable bits of the enable register and reset values.
  localparam logic [31:0] INTEN_MASK  = 32'h0000_071f;
  localparam logic [31:0] INTEN_RST   = 32'h0000_0000;
  localparam logic [15:0] TRIG_RST    = 16'h0000;
  localparam logic        TXEMPTY_RST = 1'h1;
  localparam logic        TXFULL_RST  = 1'h0;
  localparam logic [31:0] RD_RST      = 32'h0000_0000;

  typedef enum logic [1:0] {
    DW_NONE = 2'b00,
    DW_TX   = 2'b01,
    DW_RX   = 2'b10
  } sps_dma_st_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sps_bus_t;

  typedef struct packed {
    logic prog_err;
    logic rx_rd;
    logic tx_wr;
    logic tx_dma_done;
    logic rx_dma_done;
    logic len_hit;
    logic desc_end;
    logic desc_last;
    logic stop_req;
    logic byte_done;
  } sps_evt_t;

  typedef struct packed {
    logic dma_en;
    logic desc_en;
    logic close_en;
    logic tx_dma_act;
    logic rx_dma_act;
  } sps_mode_t;

  typedef struct packed {
    logic [15:0] rx_cnt;
    logic [15:0] tx_cnt;
    logic        tx_full;
  } sps_lvl_t;

endpackage

// ### core/sps_status.sv
/*
  Status flags, buffer fill counts, interrupt enables and transmit trigger of the SPI master.
  Assumes the transfer engine, buffers and DMA handshake run on the same clock and drive
  one-cycle event pulses and live buffer levels into this block.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module sps_status (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Register bus.
  input  wire sps_pkg::sps_bus_t bus,
  output logic [31:0]           rd_data,
  // Transfer engine and DMA events.
  input  wire sps_pkg::sps_evt_t evt,
  // Operating mode.
  input  wire sps_pkg::sps_mode_t mode,
  // Buffer levels.
  input  wire sps_pkg::sps_lvl_t lvl,
  // Trigger value for the engine and interrupt.
  output logic [15:0]           tx_trig,
  output logic                  irq
);

  typedef struct packed {
    sps_pkg::sps_dma_st_t dma_st;
    logic                 stop_pend;
    logic                 tx_empty;
    logic                 tx_full;
    logic [31:0]          counts;
    logic [31:0]          inten;
    logic [15:0]          trig;
    logic [31:0]          rd_data;
    logic                 irq;
  } sps_st_t;

  sps_st_t                   st_r;
  sps_st_t                   st_nxt;
  logic [sps_pkg::NFLAG-1:0] flag_set;
  logic [sps_pkg::NFLAG-1:0] flag_clr;
  logic [sps_pkg::NFLAG-1:0] flag_r;
  logic                      dma_fin;
  sps_pkg::sps_dma_st_t      dma_st_nxt;
  logic                      dma_set;
  logic                      xfer_set;
  logic                      manual;
  logic [31:0]               status_word;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic is_zero(input logic [15:0] cnt);
    is_zero = (cnt == 16'h0000);
  endfunction

  // Pairs the two DMA done indications when both directions run.
  always_comb begin
    dma_fin = 1'h0;
    dma_st_nxt = st_r.dma_st;
    if (!mode.dma_en) begin
      dma_st_nxt = sps_pkg::DW_NONE;
    end else if (!(mode.tx_dma_act && mode.rx_dma_act)) begin
      dma_fin = evt.tx_dma_done || evt.rx_dma_done;
      dma_st_nxt = sps_pkg::DW_NONE;
    end else begin
      case (st_r.dma_st)
        sps_pkg::DW_NONE: begin
          if (evt.tx_dma_done && evt.rx_dma_done) begin
            dma_fin = 1'h1;
          end else if (evt.tx_dma_done) begin
            dma_st_nxt = sps_pkg::DW_TX;
          end else if (evt.rx_dma_done) begin
            dma_st_nxt = sps_pkg::DW_RX;
          end
        end
        sps_pkg::DW_TX: begin
          if (evt.rx_dma_done) begin
            dma_fin = 1'h1;
            dma_st_nxt = sps_pkg::DW_NONE;
          end
        end
        sps_pkg::DW_RX: begin
          if (evt.tx_dma_done) begin
            dma_fin = 1'h1;
            dma_st_nxt = sps_pkg::DW_NONE;
          end
        end
        default: begin
          dma_st_nxt = sps_pkg::DW_NONE;
        end
      endcase
    end
  end

  // Completion events per mode.
  // The DMA flag is only produced with DMA enabled, so its value while disabled
  // stays whatever software last left in it and carries no meaning.
  always_comb begin
    manual = !mode.dma_en && !mode.desc_en;
    dma_set = 1'h0;
    if (mode.dma_en) begin
      if (mode.desc_en) begin
        dma_set = evt.desc_end;
      end else begin
        dma_set = dma_fin;
      end
    end
    xfer_set = 1'h0;
    if (manual && evt.len_hit) begin
      xfer_set = 1'h1;
    end
    if (mode.dma_en && !mode.desc_en && dma_set) begin
      xfer_set = 1'h1;
    end
    if (mode.desc_en && evt.desc_end && evt.desc_last) begin
      xfer_set = 1'h1;
    end
    if (mode.close_en && dma_set) begin
      xfer_set = 1'h1;
    end
    if (st_r.stop_pend && evt.byte_done) begin
      xfer_set = 1'h1;
    end
  end

  // Set terms of the sticky flags, in flag index order.
  always_comb begin
    flag_set[0] = xfer_set;
    flag_set[1] = dma_set;
    flag_set[2] = evt.tx_wr && lvl.tx_full;
    flag_set[3] = evt.rx_rd && is_zero(lvl.rx_cnt);
    flag_set[4] = evt.prog_err;
    flag_set[5] = !is_zero(st_r.trig) && (lvl.tx_cnt <= st_r.trig);
  end

  // Clear terms come only from ones written to the status register.
  genvar gi;
  generate
    for (gi = 0; gi < sps_pkg::NFLAG; gi++) begin : g_flag
      assign flag_clr[gi] = bus.wr && hit(bus.addr, sps_pkg::STATUS_OFS)
                            && bus.wdata[sps_pkg::FLAG_POS[gi]];
      sps_flag u_flag (
        .clock  (clock),
        .rst    (rst),
        .set    (flag_set[gi]),
        .clr    (flag_clr[gi]),
        .flag_r (flag_r[gi])
      );
    end
  endgenerate

  // Assembled status word; reserved bits read as zero.
  always_comb begin
    status_word = 32'h0000_0000;
    for (int i = 0; i < sps_pkg::NFLAG; i++) begin
      status_word[sps_pkg::FLAG_POS[i]] = flag_r[i];
    end
    status_word[sps_pkg::TXEMPTY_BIT] = st_r.tx_empty;
    status_word[sps_pkg::TXFULL_BIT] = st_r.tx_full;
  end

  // Registers, stop tracking, read port and interrupt.
  always_comb begin
    st_nxt.dma_st = dma_st_nxt;
    st_nxt.stop_pend = st_r.stop_pend;
    if (evt.stop_req) begin
      st_nxt.stop_pend = 1'h1;
    end else if (evt.byte_done) begin
      st_nxt.stop_pend = 1'h0;
    end
    st_nxt.tx_empty = is_zero(lvl.tx_cnt);
    st_nxt.tx_full = lvl.tx_full;
    st_nxt.counts = 32'h0000_0000;
    st_nxt.counts[sps_pkg::RXCNT_LSB +: sps_pkg::CNT_W] = lvl.rx_cnt;
    st_nxt.counts[sps_pkg::TXCNT_LSB +: sps_pkg::CNT_W] = lvl.tx_cnt;
    st_nxt.inten = st_r.inten;
    st_nxt.trig = st_r.trig;
    if (bus.wr && hit(bus.addr, sps_pkg::INTEN_OFS)) begin
      st_nxt.inten = bus.wdata & sps_pkg::INTEN_MASK;
    end
    if (bus.wr && hit(bus.addr, sps_pkg::TRIG_OFS)) begin
      st_nxt.trig = bus.wdata[sps_pkg::TRIG_LSB +: sps_pkg::CNT_W];
    end
    st_nxt.rd_data = 32'h0000_0000;
    if (bus.rd) begin
      if (hit(bus.addr, sps_pkg::STATUS_OFS)) begin
        st_nxt.rd_data = status_word;
      end else if (hit(bus.addr, sps_pkg::COUNT_OFS)) begin
        st_nxt.rd_data = st_r.counts;
      end else if (hit(bus.addr, sps_pkg::INTEN_OFS)) begin
        st_nxt.rd_data = st_r.inten;
      end else if (hit(bus.addr, sps_pkg::TRIG_OFS)) begin
        st_nxt.rd_data = {16'h0000, st_r.trig};
      end
    end
    // The line follows the flags with one cycle of lag, which keeps it glitch free.
    st_nxt.irq = |(status_word & st_r.inten);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r.dma_st <= sps_pkg::DW_NONE;
      st_r.stop_pend <= 1'h0;
      st_r.tx_empty <= sps_pkg::TXEMPTY_RST;
      st_r.tx_full <= sps_pkg::TXFULL_RST;
      st_r.counts <= 32'h0000_0000;
      st_r.inten <= sps_pkg::INTEN_RST;
      st_r.trig <= sps_pkg::TRIG_RST;
      st_r.rd_data <= sps_pkg::RD_RST;
      st_r.irq <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign tx_trig = st_r.trig;
  assign irq = st_r.irq;

endmodule // sps_status

// ### test/sps_dma_chan.sv
/*
  DMA channel model that pulses done once its programmed count runs out.
  Assumes a start pulse from the bench on the shared clock.
*/
`timescale 1ns/1ns
module sps_dma_chan #(
  parameter int LAT = 3
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Start and completion.
  input  wire logic go,
  output logic      done
);
  int cnt;
  // Done is a one-cycle pulse when the count is exhausted.
  assign done = (cnt == 1);
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= 0;
    end else if (go) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // sps_dma_chan

// ### test/sps_status_checker.sv
/*
  Port assertions for the status block.
  Assumes it is bound to sps_status and shares its single clock.
*/
`timescale 1ns/1ns
module sps_status_checker (
  // Clock and reset.
  input wire logic               clock,
  input wire logic               rst,
  // Watched ports.
  input wire sps_pkg::sps_bus_t  bus,
  input wire logic [31:0]        rd_data,
  input wire sps_pkg::sps_evt_t  evt,
  input wire sps_pkg::sps_mode_t mode,
  input wire sps_pkg::sps_lvl_t  lvl,
  input wire logic [15:0]        tx_trig,
  input wire logic               irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic st_rd;
  assign st_rd = bus.rd && bus.addr == sps_pkg::STATUS_OFS;
  // Level bits lag the live buffer by a cycle, so they are only judged on a steady level.
  empty_bit_a: assert property (st_rd && $stable(lvl.tx_cnt) && !$past(rst)
    |=> rd_data[9] == ($past(lvl.tx_cnt) == 16'h0)) else $error("empty bit wrong");
  full_bit_a: assert property (st_rd && $stable(lvl.tx_full) && !$past(rst)
    |=> rd_data[8] == $past(lvl.tx_full)) else $error("full bit wrong");
  count_copy_a: assert property (bus.rd && bus.addr == sps_pkg::COUNT_OFS
    && $stable(lvl) && !$past(rst)
    |=> rd_data == {$past(lvl.rx_cnt), $past(lvl.tx_cnt)}) else $error("counts wrong");
  txreq_set_a: assert property (tx_trig != 16'h0 && lvl.tx_cnt <= tx_trig ##1 st_rd |=> rd_data[10])
    else $error("request flag missing");
  prog_flag_a: assert property (evt.prog_err ##1 st_rd |=> rd_data[4])
    else $error("fault flag missing");
  rx_under_a: assert property (evt.rx_rd && lvl.rx_cnt == 16'h0 ##1 st_rd |=> rd_data[3])
    else $error("underflow flag missing");
  tx_over_a: assert property (evt.tx_wr && lvl.tx_full ##1 st_rd |=> rd_data[2])
    else $error("overflow flag missing");
  desc_dma_a: assert property (mode.dma_en && mode.desc_en && evt.desc_end ##1 st_rd |=> rd_data[1])
    else $error("descriptor dma flag missing");
  desc_last_a: assert property (mode.desc_en && evt.desc_end && evt.desc_last ##1 st_rd |=> rd_data[0])
    else $error("last descriptor flag missing");
  len_done_a: assert property (!mode.dma_en && !mode.desc_en && evt.len_hit ##1 st_rd |=> rd_data[0])
    else $error("manual done missing");
  trig_write_a: assert property (bus.wr && bus.addr == sps_pkg::TRIG_OFS
    |=> tx_trig == $past(bus.wdata[15:0])) else $error("trigger not written");
endmodule // sps_status_checker

// ### test/test_spi_master_status_and_counts.sv
/*
  Self-checking bench for the status block.
  Assumes the DMA channel model and the checker are compiled beforehand.
*/
`timescale 1ns/1ns
module test_spi_master_status_and_counts;
  logic               clock, rst, go, irq, txd, rxd;
  sps_pkg::sps_bus_t  bus;
  sps_pkg::sps_evt_t  ev, evt_w;
  sps_pkg::sps_mode_t mode;
  sps_pkg::sps_lvl_t  lvl;
  logic [31:0]        rd_data, v;
  logic [15:0]        tx_trig;
  int                 mismatches, n_checks, cyc;
  sps_status dut (.clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data), .evt(evt_w), .mode(mode),
    .lvl(lvl), .tx_trig(tx_trig), .irq(irq));
  sps_dma_chan #(.LAT(2)) tx_ch (.clock(clock), .rst(rst), .go(go), .done(txd));
  sps_dma_chan #(.LAT(6)) rx_ch (.clock(clock), .rst(rst), .go(go), .done(rxd));
  always_comb begin
    evt_w = ev;
    evt_w.tx_dma_done = txd;
    evt_w.rx_dma_done = rxd;
  end
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{1'h1, 1'h0, a, d};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{1'h0, 1'h1, a, 32'h0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
    d = rd_data;
  endtask
  task automatic pulse_rd(input logic [9:0] e, input logic [31:0] m, input logic [31:0] x);
    ev <= e;
    @(posedge clock);
    ev <= '0;
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & m, x);
  endtask
  task automatic t_reset();
    rd(sps_pkg::STATUS_OFS, v);
    chk(v, 32'h0000_0200);
    rd(sps_pkg::COUNT_OFS, v);
    chk(v, 32'h0000_0000);
    rd(sps_pkg::TRIG_OFS, v);
    chk(v, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_errs();
    pulse_rd(10'h080, 32'h1f, 32'h0);
    lvl <= '{16'h0, 16'h8, 1'h1};
    pulse_rd(10'h280, 32'h1f, 32'h14);
    pulse_rd(10'h100, 32'h1f, 32'h1c);
    wr(sps_pkg::STATUS_OFS, 32'h0);
    wr(sps_pkg::INTEN_OFS, 32'h10);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h1f, 32'h1c);
    chk({31'h0, irq}, 32'h1);
    rd(sps_pkg::INTEN_OFS, v);
    chk(v, 32'h0000_0010);
    // A fault arriving with its own clear must survive.
    ev <= 10'h200;
    bus <= '{1'h1, 1'h0, sps_pkg::STATUS_OFS, 32'h1c};
    @(posedge clock);
    ev <= '0;
    bus <= '0;
    @(posedge clock);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h1f, 32'h10);
    wr(sps_pkg::STATUS_OFS, 32'h10);
    // The line lags the cleared flag by one cycle.
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("error flag test done");
  endtask
  task automatic t_levels();
    lvl <= '{16'h3, 16'h5, 1'h1};
    wr(sps_pkg::TRIG_OFS, 32'h5);
    chk({16'h0, tx_trig}, 32'h0000_0005);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h700, 32'h500);
    rd(sps_pkg::COUNT_OFS, v);
    chk(v, 32'h0003_0005);
    wr(sps_pkg::TRIG_OFS, 32'h4);
    wr(sps_pkg::STATUS_OFS, 32'h400);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h700, 32'h100);
    lvl <= '0;
    wr(sps_pkg::TRIG_OFS, 32'h0);
    wr(sps_pkg::STATUS_OFS, 32'h400);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h700, 32'h200);
    $display("level test done");
  endtask
  task automatic t_modes();
    mode <= 5'h13;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    repeat (3) @(posedge clock);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h3, 32'h0);
    repeat (3) @(posedge clock);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h3, 32'h3);
    wr(sps_pkg::STATUS_OFS, 32'h3);
    mode <= 5'h18;
    pulse_rd(10'h008, 32'h3, 32'h2);
    pulse_rd(10'h00c, 32'h3, 32'h3);
    wr(sps_pkg::STATUS_OFS, 32'h3);
    mode <= '0;
    pulse_rd(10'h010, 32'h3, 32'h1);
    wr(sps_pkg::STATUS_OFS, 32'h1);
    pulse_rd(10'h002, 32'h1, 32'h0);
    pulse_rd(10'h001, 32'h1, 32'h1);
    wr(sps_pkg::STATUS_OFS, 32'h1);
    // A descriptor that is not the last still closes the transfer when closing is enabled.
    mode <= 5'h1c;
    pulse_rd(10'h008, 32'h3, 32'h3);
    wr(sps_pkg::STATUS_OFS, 32'h3);
    $display("mode test done");
  endtask
  task automatic t_dma_dir();
    mode <= 5'h12;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    repeat (2) @(posedge clock);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h3, 32'h3);
    // Let the slower channel finish before clearing, so it cannot set the flag again.
    repeat (4) @(posedge clock);
    wr(sps_pkg::STATUS_OFS, 32'h3);
    mode <= '0;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    repeat (7) @(posedge clock);
    rd(sps_pkg::STATUS_OFS, v);
    chk(v & 32'h3, 32'h0);
    $display("single direction dma test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    go = 1'h0;
    bus = '0;
    ev = '0;
    mode = '0;
    lvl = '0;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_reset();
    t_errs();
    t_levels();
    t_modes();
    t_dma_dir();
    print_verdict();
  end
endmodule // test_spi_master_status_and_counts
bind sps_status sps_status_checker chk_i (.clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data), .evt(evt),
  .mode(mode), .lvl(lvl), .tx_trig(tx_trig), .irq(irq));
